// *** rtl/i2c_master_transmit_sequencer.v ***
// Function
// R01: Four modes reached through status-coded events
// R02: Each status point sets flag, stalls bus
// R03: Software enables interface, clears start/stop/flag first
// R04: Acknowledge-assert clear means never entering slave mode
// R05: Software programs low/high bit-rate counts first
// R06: Start request waits for free bus
// R07: START sent gives flag and code 0x08
// R08: Software loads address+write, clears start, flag
// R09: Address phase ends with 0x18, 0x20, 0x38
// R10: Lost to own address gives 0x68/0x78/0xB0
// R11: 0x18 address acked, 0x20 not acked
// R12: 0x28 data acked, 0x30 not acked
// R13: No requests plus new byte: send, sample ack
// R14: Start request alone issues repeated START
// R15: Stop request sends STOP, hardware clears it
// R16: Both requests: STOP then START, stop cleared
// R17: After 0x10 send address, read enters receive
// R18: 0x38 without start releases bus, unaddressed slave
// R19: 0x38 with start retries START later
// R20: Read/nack are SDA high, write/ack low
// R21: SCL held low while flag set
// R22: Code in top five status bits
// R23: Set/clear registers change only one bits
// R24: Shift register MSB first, captures bus
// R25: Disabled interface drives nothing, no flag
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "i2c_mt_defines.vh"
module i2c_master_transmit_sequencer (
  input wire I_CLK,         // System clock, 100 MHz
  input wire I_RST_B,       // Async reset, active low
  input wire [7:0] I_ADDR,  // Register byte address
  input wire [7:0] I_WDATA, // Register write data
  input wire I_WR,          // Write strobe
  input wire I_RD,          // Read strobe
  output reg [7:0] O_RDATA, // Read data, cycle after strobe
  input wire I_SCL,         // Clock line level
  output wire O_SCL_O,      // Clock line drive value
  output wire O_SCL_OE,     // Clock line pulled low
  input wire I_SDA,         // Data line level
  output wire O_SDA_O,      // Data line drive value
  output wire O_SDA_OE      // Data line pulled low
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_START = 4'h1;
  localparam S_WAIT = 4'h2;
  localparam S_LOW = 4'h3;
  localparam S_HIGH = 4'h4;
  localparam S_STOP1 = 4'h5;
  localparam S_STOP2 = 4'h6;
  localparam S_STOP3 = 4'h7;
  localparam S_RS1 = 4'h8;
  localparam S_RS2 = 4'h9;

  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg [7:0] own_reg;
  reg [7:0] clk_high_count;
  reg [7:0] clk_low_count;
  reg [7:0] shift_byte_reg;
  reg [4:0] code_reg;
  reg [3:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg scl_oe_reg;
  reg sda_oe_reg;
  reg si_set_reg;
  reg halt_clr_reg;
  reg tmr_load_reg;
  reg [7:0] tmr_val_reg;
  reg hi_run_reg;
  reg lost_reg;
  reg match_reg;
  reg gc_reg;
  reg slv_rd_reg;
  reg rx_mode_reg;
  reg addr_phase_reg;
  reg after_start_reg;
  reg rs_reg;
  reg busy_reg;
  reg sda_d_reg;
  reg sda_nxt_reg;

  wire [1:0] line_s;
  wire scl_s = line_s[1];
  wire sda_s = line_s[0];
  wire tmr_done;
  wire iface_on = ctrl_reg[`B_IFACE_ON];
  wire begin_cond_req = ctrl_reg[`B_BEGIN];
  wire halt_cond_req = ctrl_reg[`B_HALT];
  wire si_flag = ctrl_reg[`B_SI];
  wire ack_assert = ctrl_reg[`B_ACK];

  // ----------------------------------------
  // Bus line sampling and timing
  // ----------------------------------------
  line_sync u_sync (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_pin({I_SCL, I_SDA}),
    .o_sync(line_s)
  );

  scl_timer u_timer (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_load(tmr_load_reg),
    .i_count(tmr_val_reg),
    .o_done(tmr_done)
  );

  // Open-drain: the pin is only ever pulled low
  assign O_SCL_O = 1'b0;
  assign O_SDA_O = 1'b0;
  assign O_SCL_OE = scl_oe_reg;
  assign O_SDA_OE = sda_oe_reg;

  // ----------------------------------------
  // Bus busy tracking
  // ----------------------------------------
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sda_d_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      sda_d_reg <= sda_s;
      if (scl_s && sda_d_reg && !sda_s) begin
        busy_reg <= 1'b1;
      end else if (scl_s && !sda_d_reg && sda_s) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Hardware set of the flag and software set of stop win over clears
  always @* begin
    ctrl_next = ctrl_reg;
    if (halt_clr_reg) begin
      ctrl_next[`B_HALT] = 1'b0; // [R15] [R16]
    end
    if (I_WR && I_ADDR == `R_CTRL_CLR) begin
      ctrl_next = ctrl_next & ~(I_WDATA & `CTRL_MASK); // [R23]
    end
    if (I_WR && I_ADDR == `R_CTRL_SET) begin
      ctrl_next = ctrl_next | (I_WDATA & `CTRL_MASK); // [R23]
    end
    if (si_set_reg) begin
      ctrl_next[`B_SI] = 1'b1; // [R02]
    end
  end

  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_reg <= `RST_CTRL;
      own_reg <= `RST_OWN_ADDR;
      clk_high_count <= `RST_SCL_COUNT;
      clk_low_count <= `RST_SCL_COUNT;
    end else begin
      ctrl_reg <= ctrl_next;
      if (I_WR && I_ADDR == `R_OWN_ADDR) begin
        own_reg <= I_WDATA;
      end
      if (I_WR && I_ADDR == `R_SCL_HIGH) begin
        clk_high_count <= I_WDATA; // [R05]
      end
      if (I_WR && I_ADDR == `R_SCL_LOW) begin
        clk_low_count <= I_WDATA; // [R05]
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  wire [7:0] status_w = si_flag ? {code_reg, 3'b000} : `ST_NO_INFO; // [R22]

  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        `R_CTRL_SET: O_RDATA <= ctrl_reg;
        `R_STATUS: O_RDATA <= status_w;
        `R_DATA: O_RDATA <= shift_byte_reg;
        `R_OWN_ADDR: O_RDATA <= own_reg;
        `R_SCL_HIGH: O_RDATA <= clk_high_count;
        `R_SCL_LOW: O_RDATA <= clk_low_count;
        default: O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // Bit-level decisions
  // ----------------------------------------
  wire rx_w = rx_mode_reg & ~addr_phase_reg;
  wire [7:0] byte_now = {shift_byte_reg[6:0], sda_s};
  // We released SDA for a one but the line reads low
  wire arb_fail = ~sda_oe_reg & ~sda_s & ~lost_reg &
                  (bit_cnt_reg == 4'h8 ? rx_w & ~ack_assert : ~rx_w);
  wire lost_now = lost_reg | arb_fail;
  wire gc_now = (byte_now[7:1] == 7'h00);
  // Address match only counts when acknowledging is enabled
  wire own_hit = ack_assert & addr_phase_reg &
                 ((byte_now[7:1] == own_reg[7:1]) | (gc_now & own_reg[0])); // [R04]
  wire hi_go = hi_run_reg & (tmr_done | ~scl_s);
  wire [7:0] start_code = rs_reg ? `ST_RSTART : `ST_START; // [R07]
  reg next_low;
  reg [7:0] end_code;

  // Drive level for the bit after the one being sampled
  always @* begin
    if (bit_cnt_reg == 4'h7) begin
      next_low = lost_now ? own_hit : (rx_w ? ack_assert : 1'b0); // [R20]
    end else begin
      next_low = ~lost_now & ~rx_w & ~shift_byte_reg[6]; // [R20]
    end
  end

  // Code reported once the acknowledge bit is sampled
  always @* begin
    if (lost_now) begin
      if (match_reg) begin
        end_code = gc_reg ? `ST_SLV_GC : (slv_rd_reg ? `ST_SLV_R : `ST_SLV_W); // [R10]
      end else begin
        end_code = `ST_ARB_LOST; // [R18]
      end
    end else if (addr_phase_reg) begin
      if (rx_mode_reg) begin
        end_code = sda_s ? `ST_AR_NACK : `ST_AR_ACK; // [R17]
      end else begin
        end_code = sda_s ? `ST_AW_NACK : `ST_AW_ACK; // [R09] [R11]
      end
    end else if (rx_mode_reg) begin
      end_code = sda_s ? `ST_DR_NACK : `ST_DR_ACK; // [R01]
    end else begin
      end_code = sda_s ? `ST_DW_NACK : `ST_DW_ACK; // [R12]
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      si_set_reg <= 1'b0;
      halt_clr_reg <= 1'b0;
      tmr_load_reg <= 1'b0;
      tmr_val_reg <= 8'h00;
      hi_run_reg <= 1'b0;
      lost_reg <= 1'b0;
      match_reg <= 1'b0;
      gc_reg <= 1'b0;
      slv_rd_reg <= 1'b0;
      rx_mode_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      after_start_reg <= 1'b0;
      rs_reg <= 1'b0;
      code_reg <= 5'h1F;
      shift_byte_reg <= 8'h00;
      sda_nxt_reg <= 1'b0;
    end else begin
      si_set_reg <= 1'b0;
      halt_clr_reg <= 1'b0;
      tmr_load_reg <= 1'b0;
      // Software loads are kept out of a byte in flight
      if (I_WR && I_ADDR == `R_DATA && state_reg != S_LOW && state_reg != S_HIGH) begin
        shift_byte_reg <= I_WDATA;
      end
      if (!iface_on) begin
        state_reg <= S_IDLE; // [R25]
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
        hi_run_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            lost_reg <= 1'b0;
            if (begin_cond_req && !busy_reg && !si_flag && scl_s && sda_s) begin
              sda_oe_reg <= 1'b1; // [R06] [R19]
              rs_reg <= 1'b0;
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_high_count;
              state_reg <= S_START;
            end
          end
          S_START: begin
            if (tmr_done) begin
              scl_oe_reg <= 1'b1;
              si_set_reg <= 1'b1; // [R07]
              code_reg <= start_code[7:3]; // [R07] [R22]
              after_start_reg <= 1'b1;
              state_reg <= S_WAIT;
            end
          end
          S_WAIT: begin
            scl_oe_reg <= 1'b1; // [R21]
            // Acknowledge drive ends only once SCL is already held low
            if (si_set_reg && !after_start_reg) begin
              sda_oe_reg <= 1'b0;
            end
            if (!si_flag && !si_set_reg) begin
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_low_count;
              if (lost_reg) begin
                // Slave service is outside this block: just let go
                scl_oe_reg <= 1'b0; // [R18] [R19]
                sda_oe_reg <= 1'b0;
                state_reg <= S_IDLE;
              end else if (halt_cond_req) begin
                sda_oe_reg <= 1'b1; // [R15] [R16]
                halt_clr_reg <= 1'b1;
                state_reg <= S_STOP1;
              end else if (begin_cond_req && !after_start_reg) begin
                sda_oe_reg <= 1'b0; // [R14]
                state_reg <= S_RS1;
              end else begin
                bit_cnt_reg <= 4'h0; // [R13]
                addr_phase_reg <= after_start_reg;
                after_start_reg <= 1'b0;
                match_reg <= 1'b0;
                if (after_start_reg) begin
                  rx_mode_reg <= shift_byte_reg[0]; // [R17]
                  sda_oe_reg <= ~shift_byte_reg[7]; // [R24]
                end else begin
                  sda_oe_reg <= ~rx_mode_reg & ~shift_byte_reg[7];
                end
                state_reg <= S_LOW;
              end
            end
          end
          S_LOW: begin
            // SDA moves a cycle after SCL falls so slaves see hold time
            if (tmr_load_reg && bit_cnt_reg != 4'h0) begin
              sda_oe_reg <= sda_nxt_reg; // [R20]
            end
            if (tmr_done) begin
              scl_oe_reg <= 1'b0;
              state_reg <= S_HIGH;
            end
          end
          S_HIGH: begin
            // Waiting for SCL high lets slaves and other masters stretch
            if (!hi_run_reg && scl_s) begin
              hi_run_reg <= 1'b1;
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_high_count;
            end else if (hi_go) begin
              hi_run_reg <= 1'b0;
              scl_oe_reg <= 1'b1;
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_low_count;
              lost_reg <= lost_now; // [R18]
              if (bit_cnt_reg == 4'h8) begin
                si_set_reg <= 1'b1; // [R02] [R09]
                code_reg <= end_code[7:3]; // [R22]
                state_reg <= S_WAIT;
              end else begin
                shift_byte_reg <= byte_now; // [R24]
                if (bit_cnt_reg == 4'h7) begin
                  match_reg <= own_hit; // [R10]
                  gc_reg <= gc_now;
                  slv_rd_reg <= byte_now[0];
                end
                sda_nxt_reg <= next_low; // [R20]
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                state_reg <= S_LOW;
              end
            end
          end
          S_STOP1: begin
            if (tmr_done) begin
              scl_oe_reg <= 1'b0;
              state_reg <= S_STOP2;
            end
          end
          S_STOP2: begin
            if (!hi_run_reg && scl_s) begin
              hi_run_reg <= 1'b1;
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_high_count;
            end else if (hi_go) begin
              hi_run_reg <= 1'b0;
              sda_oe_reg <= 1'b0; // [R15]
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_high_count;
              state_reg <= S_STOP3;
            end
          end
          S_STOP3: begin
            // Idle starts anew if the start request is still set
            if (tmr_done) begin
              state_reg <= S_IDLE; // [R16]
            end
          end
          S_RS1: begin
            if (tmr_done) begin
              scl_oe_reg <= 1'b0;
              state_reg <= S_RS2;
            end
          end
          S_RS2: begin
            if (!hi_run_reg && scl_s) begin
              hi_run_reg <= 1'b1;
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_high_count;
            end else if (hi_go) begin
              hi_run_reg <= 1'b0;
              sda_oe_reg <= 1'b1; // [R14]
              rs_reg <= 1'b1;
              tmr_load_reg <= 1'b1;
              tmr_val_reg <= clk_high_count;
              state_reg <= S_START;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// *** rtl/i2c_mt_defines.vh ***
`ifndef I2C_MT_DEFINES_VH
`define I2C_MT_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define R_CTRL_SET 8'h00
`define R_STATUS 8'h04
`define R_DATA 8'h08
`define R_OWN_ADDR 8'h0C
`define R_SCL_HIGH 8'h10
`define R_SCL_LOW 8'h14
`define R_CTRL_CLR 8'h18

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define B_IFACE_ON 6
`define B_BEGIN 5
`define B_HALT 4
`define B_SI 3
`define B_ACK 2
`define CTRL_MASK 8'h7C
`define RST_CTRL 8'h00
`define RST_OWN_ADDR 8'h00
`define RST_SCL_COUNT 8'h04

// ----------------------------------------
// Status codes
// ----------------------------------------
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_AW_ACK 8'h18
`define ST_AW_NACK 8'h20
`define ST_DW_ACK 8'h28
`define ST_DW_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_AR_ACK 8'h40
`define ST_AR_NACK 8'h48
`define ST_DR_ACK 8'h50
`define ST_DR_NACK 8'h58
`define ST_SLV_W 8'h68
`define ST_SLV_GC 8'h78
`define ST_SLV_R 8'hB0
`define ST_NO_INFO 8'hF8

`endif

// *** rtl/line_sync.v ***
`timescale 1ns/10ps
module line_sync (
  input wire i_clk,        // System clock
  input wire i_rst_b,      // Async reset, active low
  input wire [1:0] i_pin,  // Raw bus lines
  output wire [1:0] o_sync // Synchronised lines
);
  reg [1:0] meta_reg;
  reg [1:0] sync_reg;

  // Lines idle high, so reset to the released level
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// *** rtl/scl_timer.v ***
`timescale 1ns/10ps
module scl_timer (
  input wire i_clk,        // System clock
  input wire i_rst_b,      // Async reset, active low
  input wire i_load,       // Load pulse
  input wire [7:0] i_count, // Cycles to time
  output wire o_done       // Count expired
);
  reg [7:0] cnt_reg;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 8'h00;
    end else if (i_load) begin
      cnt_reg <= i_count;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Masked during load so the caller never sees a stale expiry
  assign o_done = (cnt_reg == 8'h00) & ~i_load;
endmodule

// *** tb/i2c_slave_model.sv ***
`timescale 1ns/10ps
module i2c_slave_model (
  input wire i_scl,        // Clock line level
  input wire i_sda,        // Data line level
  input wire [6:0] i_addr7, // Address answered
  input wire i_nack,       // Refuse data bytes
  input wire i_slow,       // Stretch after each ack
  output reg o_scl_oe,     // Pull clock line low
  output reg o_sda_oe,     // Pull data line low
  output reg [7:0] o_byte, // Last byte taken
  output reg [7:0] o_stops // STOP conditions seen
);
  reg [7:0] sh;
  reg first;
  reg sel;
  integer bitn;
  initial begin
    o_scl_oe = 1'h0;
    o_sda_oe = 1'h0;
    o_byte = 8'h00;
    o_stops = 8'h00;
    sh = 8'h00;
    first = 1'h0;
    sel = 1'h0;
    bitn = 0;
  end
  always @(negedge i_sda) if (i_scl) begin
    bitn = 0;
    first = 1'h1;
  end
  always @(posedge i_sda) if (i_scl) begin
    o_stops = o_stops + 8'h01;
    sel = 1'h0;
  end
  always @(posedge i_scl) if (bitn < 8) begin
    sh = {sh[6:0], i_sda};
    bitn = bitn + 1;
  end
  // Behavioural on line edges: only a master that waits for SCL high can pass
  always @(negedge i_scl) begin
    if (bitn == 8) begin
      if (first) sel = (sh[7:1] == i_addr7) && !sh[0];
      else if (sel) o_byte = sh;
      o_sda_oe = sel && (first || !i_nack);
      first = 1'h0;
      bitn = 9;
    end else if (bitn == 9) begin
      o_sda_oe = 1'h0;
      bitn = 0;
      if (i_slow) begin
        o_scl_oe = 1'h1;
        #400;
        o_scl_oe = 1'h0;
      end
    end
  end
endmodule

// *** tb/i2c_mt_chk.sv ***
`timescale 1ns/10ps
`include "i2c_mt_defines.vh"
module i2c_mt_chk (
  input wire I_CLK,         // System clock
  input wire I_RST_B,       // Async reset, active low
  input wire [7:0] I_ADDR,  // Register address
  input wire [7:0] I_WDATA, // Write data
  input wire I_WR,          // Write strobe
  input wire I_RD,          // Read strobe
  input wire [7:0] O_RDATA, // Read data
  input wire I_SCL,         // Clock line level
  input wire O_SCL_O,       // Clock drive value
  input wire O_SCL_OE,      // Clock pulled low
  input wire I_SDA,         // Data line level
  input wire O_SDA_O,       // Data drive value
  input wire O_SDA_OE       // Data pulled low
);
  // ----------------------------------------
  // Shadow of enable and of a flag seen set
  // ----------------------------------------
  reg en_reg;
  reg si_reg;
  reg rd_d_reg;
  reg [7:0] addr_d_reg;
  wire clr_wr = I_WR && (I_ADDR == `R_CTRL_CLR);
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      en_reg <= 1'h0;
      si_reg <= 1'h0;
      rd_d_reg <= 1'h0;
      addr_d_reg <= 8'h00;
    end else begin
      rd_d_reg <= I_RD;
      addr_d_reg <= I_ADDR;
      if (I_WR && (I_ADDR == `R_CTRL_SET) && I_WDATA[6]) en_reg <= 1'h1;
      else if (clr_wr && I_WDATA[6]) en_reg <= 1'h0;
      // Only a status read proves the flag set, so this lags it safely
      if (clr_wr && (I_WDATA[3] || I_WDATA[6])) si_reg <= 1'h0;
      else if (rd_d_reg && (addr_d_reg == `R_STATUS) && (O_RDATA != `ST_NO_INFO))
        si_reg <= 1'h1;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_start;
    $rose(O_SDA_OE) && I_SCL && !O_SCL_OE && !$past(O_SCL_OE);
  endsequence
  sequence s_stop;
    $fell(O_SDA_OE) && I_SCL && !O_SCL_OE && !$past(O_SCL_OE);
  endsequence
  a_stat_low_zero: assert property ($past(I_RD) && ($past(I_ADDR) == `R_STATUS) |->
    O_RDATA[2:0] == 3'h0) else $error("status low bits not zero");
  a_ctrl_bit_mask: assert property ($past(I_RD) && ($past(I_ADDR) == `R_CTRL_SET) |->
    (O_RDATA & ~`CTRL_MASK) == 8'h00) else $error("unused control bits set");
  a_clear_reads_zero: assert property ($past(I_RD) && ($past(I_ADDR) == `R_CTRL_CLR) |->
    O_RDATA == 8'h00) else $error("clear register read not zero");
  a_pins_open_drain: assert property (O_SCL_O == 1'h0 && O_SDA_O == 1'h0)
    else $error("line driven high");
  a_off_no_drive: assert property (!en_reg && !$past(en_reg) |->
    !O_SCL_OE && !O_SDA_OE) else $error("bus driven while disabled");
  a_flag_holds_scl: assert property (si_reg |-> O_SCL_OE)
    else $error("clock released while flag set");
  a_start_hold: assert property (s_start |-> !O_SCL_OE [*2])
    else $error("start hold too short");
  a_stop_idle: assert property (s_stop |-> !O_SCL_OE [*3])
    else $error("clock pulled right after stop");
endmodule
bind i2c_master_transmit_sequencer i2c_mt_chk i2c_mt_chk_inst (.I_CLK(I_CLK),
  .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .O_RDATA(O_RDATA), .I_SCL(I_SCL), .O_SCL_O(O_SCL_O), .O_SCL_OE(O_SCL_OE),
  .I_SDA(I_SDA), .O_SDA_O(O_SDA_O), .O_SDA_OE(O_SDA_OE));

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`include "i2c_mt_defines.vh"
`define CHK(nm, e, g) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; $display("MISMATCH %0s expected %h seen %h", nm, e, g); end end
module testbench;
  reg clk = 1'h0;
  reg rst_b = 1'h0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'h0;
  reg rd = 1'h0;
  reg nack = 1'h0;
  reg slow = 1'h0;
  reg [6:0] slv_addr = 7'h00;
  reg [7:0] v, d, st, stops;
  wire [7:0] rdata, slv_byte, slv_stops;
  wire scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  wire scl = !(scl_oe | s_scl_oe);
  wire sda = !(sda_oe | s_sda_oe);
  integer mismatches = 0;
  integer n_compared = 0;
  integer seed = 59247;
  integer cycles = 0;
  integer i, r;
  localparam [63:0] RA = {`R_CTRL_SET, `R_STATUS, `R_DATA, `R_OWN_ADDR, `R_SCL_HIGH,
    `R_SCL_LOW, `R_CTRL_CLR, 8'h20};
  localparam [63:0] RV = {8'h00, 8'hF8, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
  i2c_master_transmit_sequencer i2c_master_transmit_sequencer_inst (.I_CLK(clk),
    .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_SCL(scl), .O_SCL_O(), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA_O(), .O_SDA_OE(sda_oe));
  i2c_slave_model i2c_slave_model_inst (.i_scl(scl), .i_sda(sda), .i_addr7(slv_addr),
    .i_nack(nack), .i_slow(slow), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe),
    .o_byte(slv_byte), .o_stops(slv_stops));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task wr_reg(input [7:0] a, input [7:0] dv);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= dv;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
    end
  endtask
  task rd_reg(input [7:0] a, output [7:0] dv);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 dv = rdata;
    end
  endtask
  // Polling keeps the wait bounded even if the flag never sets
  task wait_si(output [7:0] s);
    integer k;
    begin
      s = `ST_NO_INFO;
      for (k = 0; k < 1500 && s === `ST_NO_INFO; k = k + 1) rd_reg(`R_STATUS, s);
    end
  endtask
  task step(input ld, input [7:0] dv, input [7:0] setb, input [7:0] clrb, output [7:0] s);
    begin
      if (ld) wr_reg(`R_DATA, dv);
      if (setb != 8'h00) wr_reg(`R_CTRL_SET, setb);
      wr_reg(`R_CTRL_CLR, clrb);
      wait_si(s);
    end
  endtask
  function [7:0] exp_code(input data, input acked);
    exp_code = data ? (acked ? `ST_DW_ACK : `ST_DW_NACK) : (acked ? `ST_AW_ACK : `ST_AW_NACK);
  endfunction
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    r = $random(seed);
    slv_addr = r[6:0];
    for (i = 7; i >= 0; i = i - 1) begin
      rd_reg(RA[i*8+:8], v);
      `CHK("reset value", RV[i*8+:8], v)
    end
    wr_reg(`R_CTRL_SET, 8'h84);
    rd_reg(`R_CTRL_SET, v);
    `CHK("ctrl set", 8'h04, v)
    wr_reg(`R_CTRL_CLR, 8'h04);
    wr_reg(`R_CTRL_SET, 8'h20);
    repeat (200) @(posedge clk);
    rd_reg(`R_STATUS, v);
    `CHK("disabled status", `ST_NO_INFO, v)
    wr_reg(`R_CTRL_CLR, 8'h20);
    rd_reg(`R_CTRL_SET, v);
    `CHK("ctrl clear", 8'h00, v)
    $display("test registers done");
    r = $random(seed);
    wr_reg(`R_SCL_LOW, 8'h04 + {6'h00, r[1:0]});
    wr_reg(`R_SCL_HIGH, 8'h04 + {6'h00, r[3:2]});
    wr_reg(`R_CTRL_SET, 8'h40);
    step(1'h0, 8'h00, 8'h20, 8'h00, st);
    `CHK("start code", `ST_START, st)
    rd_reg(`R_CTRL_SET, v);
    `CHK("ctrl at start", 8'h68, v)
    step(1'h1, {slv_addr, 1'h0}, 8'h00, 8'h28, st);
    `CHK("address code", exp_code(1'h0, 1'h1), st)
    for (i = 0; i < 4; i = i + 1) begin
      nack = (i == 3);
      slow = i[0];
      r = $random(seed);
      d = r[7:0];
      step(1'h1, d, 8'h00, 8'h08, st);
      `CHK("data code", exp_code(1'h1, !nack), st)
      `CHK("byte received", d, slv_byte)
      rd_reg(`R_DATA, v);
      `CHK("shift byte", d, v)
    end
    nack = 1'h0;
    $display("test write done");
    step(1'h0, 8'h00, 8'h20, 8'h08, st);
    `CHK("repeated start", `ST_RSTART, st)
    step(1'h1, {~slv_addr[6], slv_addr[5:0], 1'h0}, 8'h00, 8'h28, st);
    `CHK("wrong address", exp_code(1'h0, 1'h0), st)
    stops = slv_stops;
    step(1'h0, 8'h00, 8'h30, 8'h08, st);
    `CHK("stop then start", `ST_START, st)
    `CHK("stops seen", stops + 8'h01, slv_stops)
    rd_reg(`R_CTRL_SET, v);
    `CHK("halt cleared", 8'h68, v)
    step(1'h1, {slv_addr, 1'h0}, 8'h00, 8'h28, st);
    `CHK("address again", `ST_AW_ACK, st)
    step(1'h0, 8'h00, 8'h20, 8'h08, st);
    `CHK("second restart", `ST_RSTART, st)
    step(1'h1, {slv_addr, 1'h1}, 8'h00, 8'h28, st);
    `CHK("read address", `ST_AR_NACK, st)
    $display("test restart done");
    wr_reg(`R_CTRL_SET, 8'h10);
    wr_reg(`R_CTRL_CLR, 8'h08);
    repeat (300) @(posedge clk);
    rd_reg(`R_CTRL_SET, v);
    `CHK("after stop", 8'h40, v)
    `CHK("stop seen", stops + 8'h02, slv_stops)
    rd_reg(`R_STATUS, v);
    `CHK("idle status", `ST_NO_INFO, v)
    $display("test stop done");
    summarize;
  end
endmodule
